// >>> hdl/timer_capture_pkg.sv
// Package with register map, fields and types of the capture timer
package timer_capture_pkg;
   // Register offsets (word indices; byte address is four times the index)
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_IRQ_ENABLE = 5'h05;
   localparam logic [4:0] OFS_IRQ_FLAG = 5'h06;
   localparam logic [4:0] OFS_RUN_STATUS = 5'h07;
   localparam logic [4:0] OFS_DEBUG_CTRL = 5'h08;
   localparam logic [4:0] OFS_STAGING = 5'h09;
   localparam logic [4:0] OFS_COUNT_LO = 5'h0A;
   localparam logic [4:0] OFS_COUNT_HI = 5'h0B;
   localparam logic [4:0] OFS_CAPTURE_COMPARE_VALUE_LO = 5'h0C;
   localparam logic [4:0] OFS_CAPTURE_COMPARE_VALUE_HI = 5'h0D;
   // Field positions
   localparam int CAPTURE_EVENT_FLAG_BIT = 0;
   localparam int RUN_BIT = 0;
   localparam int RUN_IN_DEBUG_HALT_BIT = 0;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_EDGE_BIT = 1;
   localparam int CTRL_MODE_LSB = 4;
   // Reset values
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
   // Bus answers
   localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECODEERROR = 2'h3;

   // Counter modes
   typedef enum logic [2:0] {
      MODE_PERIODIC = 3'h0,
      MODE_TIMEOUT = 3'h1,
      MODE_CAPTURE = 3'h2,
      MODE_FREQ = 3'h3,
      MODE_PULSE = 3'h4,
      MODE_FREQ_PULSE = 3'h5,
      MODE_SINGLE = 3'h6,
      MODE_PWM8 = 3'h7
   } counter_mode_select_t;

   // Combined frequency/pulse-width sequence, Gray coded
   typedef enum logic [1:0] {
      FP_WAIT_FIRST = 2'b00,
      FP_WAIT_MID = 2'b01,
      FP_WAIT_SECOND = 2'b11,
      FP_DONE = 2'b10
   } freq_pulse_state_t;

   // Avalon-MM request
   typedef struct packed {
      logic read;
      logic write;
      logic [6:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } avmm_req_t;

   // Avalon-MM answer
   typedef struct packed {
      logic waitrequest;
      logic readdatavalid;
      logic [31:0] readdata;
      logic [1:0] response;
   } avmm_rsp_t;
endpackage

// >>> hdl/timer_capture_regs.sv
// Capture/compare timer with status, count and capture registers
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module timer_capture_regs
   import timer_capture_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire avmm_req_t busReq,
   output avmm_rsp_t busRsp,
   input wire logic eventIn,
   input wire logic debugHalt,
   output logic irq,
   output logic pwmOut
);

   logic [1:0] eventSync_reg;
   logic eventPrev_reg;
   logic [1:0] haltSync_reg;
   logic [7:0] ctrl_reg;
   logic irqEnable_reg;
   logic captFlag_reg;
   logic run_in_debug_halt_reg;
   logic [7:0] staging_reg;
   logic [15:0] count_reg;
   logic [15:0] capture_compare_value_reg;
   logic running_reg;
   logic pwmOut_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic [1:0] resp_reg;
   freq_pulse_state_t fp_reg;

   counter_mode_select_t mode;
   logic enable, edgeSel, halted, rise, fall, actEdge, oppEdge;
   logic access, wr, rd, byteWr, hit;
   logic [4:0] ofs;
   logic [7:0] wdata;
   logic topHit, capture, restart, stopNow, flagSet, flagClr;
   logic [15:0] top;

   // Byte lane of a write to this register
   function automatic logic isWrite(input logic [4:0] off,
                                    input logic [4:0] target,
                                    input logic doWrite);
      isWrite = doWrite && (off == target);
   endfunction

   // Mode field and controls
   assign mode = counter_mode_select_t'(ctrl_reg[CTRL_MODE_LSB +: 3]);
   assign enable = ctrl_reg[CTRL_ENABLE_BIT];
   assign edgeSel = ctrl_reg[CTRL_EDGE_BIT];
   assign halted = haltSync_reg[1] && !run_in_debug_halt_reg;

   // Event edge detection on synchronised input
   assign rise = eventSync_reg[1] && !eventPrev_reg && !halted;
   assign fall = !eventSync_reg[1] && eventPrev_reg && !halted;
   assign actEdge = edgeSel ? fall : rise;
   assign oppEdge = edgeSel ? rise : fall;

   // Bus decode: one aligned word per byte register
   assign access = (busReq.read || busReq.write) && !ack_reg;
   assign ofs = busReq.address[6:2];
   assign wr = access && busReq.write && busReq.byteenable[0];
   assign rd = access && busReq.read;
   assign wdata = busReq.writedata[7:0];
   assign byteWr = wr;
   assign hit = (ofs == OFS_CTRL) || (ofs >= OFS_IRQ_ENABLE &&
                ofs <= OFS_CAPTURE_COMPARE_VALUE_HI);

   // Top value per mode
   always_comb begin
      if (mode == MODE_PWM8) begin
         top = {8'h00, capture_compare_value_reg[7:0]};
      end else begin
         top = capture_compare_value_reg;
      end
   end

   // Mode-dependent count events
   always_comb begin
      topHit = 1'b0;
      capture = 1'b0;
      restart = 1'b0;
      stopNow = 1'b0;
      case (mode)
         // Halt freezes the count, so a frozen top must not wrap or flag
         MODE_PERIODIC, MODE_TIMEOUT, MODE_SINGLE: begin
            topHit = running_reg && !halted && (count_reg == top);
         end
         MODE_PWM8: begin
            topHit = running_reg && !halted && (count_reg == top);
         end
         MODE_CAPTURE: begin
            capture = enable && actEdge;
         end
         MODE_FREQ: begin
            capture = enable && actEdge;
            restart = capture;
         end
         MODE_PULSE: begin
            restart = enable && actEdge;
            capture = enable && oppEdge;
         end
         MODE_FREQ_PULSE: begin
            restart = enable && actEdge && fp_reg == FP_WAIT_FIRST;
            capture = enable && oppEdge && fp_reg == FP_WAIT_MID;
            stopNow = enable && actEdge && fp_reg == FP_WAIT_SECOND;
         end
         default: begin
            topHit = 1'b0;
         end
      endcase
   end

   // Flag set and clear; set wins
   assign flagSet = topHit || stopNow ||
                    (capture && mode != MODE_FREQ_PULSE);
   assign flagClr = (isWrite(ofs, OFS_IRQ_FLAG, byteWr) && wdata[CAPTURE_EVENT_FLAG_BIT])
      || (rd && (ofs == OFS_CAPTURE_COMPARE_VALUE_LO || ofs == OFS_CAPTURE_COMPARE_VALUE_HI) &&
          mode inside {MODE_CAPTURE, MODE_FREQ, MODE_PULSE,
                       MODE_FREQ_PULSE});

   // Synchronisers for pins
   always_ff @(posedge clk) begin
      if (reset) begin
         eventSync_reg <= 2'b00;
         eventPrev_reg <= 1'b0;
         haltSync_reg <= 2'b00;
      end else begin
         eventSync_reg <= {eventSync_reg[0], eventIn};
         eventPrev_reg <= eventSync_reg[1];
         haltSync_reg <= {haltSync_reg[0], debugHalt};
      end
   end

   // Control and simple registers
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_reg <= BYTE_RESET;
         irqEnable_reg <= 1'b0;
         run_in_debug_halt_reg <= 1'b0;
      end else begin
         if (isWrite(ofs, OFS_CTRL, byteWr)) begin
            ctrl_reg <= wdata;
         end
         if (isWrite(ofs, OFS_IRQ_ENABLE, byteWr)) begin
            irqEnable_reg <= wdata[CAPTURE_EVENT_FLAG_BIT];
         end
         if (isWrite(ofs, OFS_DEBUG_CTRL, byteWr)) begin
            run_in_debug_halt_reg <= wdata[RUN_IN_DEBUG_HALT_BIT];
         end
      end
   end

   // Capture flag
   always_ff @(posedge clk) begin
      if (reset) begin
         captFlag_reg <= 1'b0;
      end else if (flagSet) begin
         captFlag_reg <= 1'b1;
      end else if (flagClr) begin
         captFlag_reg <= 1'b0;
      end
   end

   // Staging byte for 16-bit access
   always_ff @(posedge clk) begin
      if (reset) begin
         staging_reg <= BYTE_RESET;
      end else if (rd && ofs == OFS_COUNT_LO) begin
         staging_reg <= count_reg[15:8];
      end else if (rd && ofs == OFS_CAPTURE_COMPARE_VALUE_LO) begin
         staging_reg <= capture_compare_value_reg[15:8];
      end else if (isWrite(ofs, OFS_STAGING, byteWr) ||
                   isWrite(ofs, OFS_COUNT_HI, byteWr) ||
                   isWrite(ofs, OFS_CAPTURE_COMPARE_VALUE_HI, byteWr)) begin
         staging_reg <= wdata;
      end
   end

   // Running state
   always_ff @(posedge clk) begin
      if (reset) begin
         running_reg <= 1'b0;
      end else if (!enable) begin
         running_reg <= 1'b0;
      end else if (mode == MODE_TIMEOUT) begin
         if (actEdge) begin
            running_reg <= 1'b1;
         end else if (oppEdge) begin
            running_reg <= 1'b0;
         end
      end else if (mode == MODE_SINGLE) begin
         if (actEdge) begin
            running_reg <= 1'b1;
         end else if (topHit) begin
            running_reg <= 1'b0;
         end
      end else if (mode == MODE_FREQ_PULSE) begin
         if (stopNow) begin
            running_reg <= 1'b0;
         end else if (restart) begin
            running_reg <= 1'b1;
         end
      end else begin
         running_reg <= 1'b1;
      end
   end

   // Combined-mode edge sequence
   always_ff @(posedge clk) begin
      if (reset || mode != MODE_FREQ_PULSE || !enable) begin
         fp_reg <= FP_WAIT_FIRST;
      end else begin
         case (fp_reg)
            FP_WAIT_FIRST: if (restart) begin
               fp_reg <= FP_WAIT_MID;
            end
            FP_WAIT_MID: if (capture) begin
               fp_reg <= FP_WAIT_SECOND;
            end
            FP_WAIT_SECOND: if (stopNow) begin
               fp_reg <= FP_DONE;
            end
            FP_DONE: if (flagClr) begin
               fp_reg <= FP_WAIT_FIRST;
            end
            default: fp_reg <= FP_WAIT_FIRST;
         endcase
      end
   end

   // Counter; bus writes take precedence
   always_ff @(posedge clk) begin
      if (reset) begin
         count_reg <= WORD_RESET;
      end else if (isWrite(ofs, OFS_COUNT_LO, byteWr)) begin
         count_reg <= {staging_reg, wdata};
      end else if (restart || topHit) begin
         count_reg <= COUNT_BOTTOM;
      end else if (running_reg && !halted) begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   // Capture/compare register
   always_ff @(posedge clk) begin
      if (reset) begin
         capture_compare_value_reg <= WORD_RESET;
      end else if (isWrite(ofs, OFS_CAPTURE_COMPARE_VALUE_LO, byteWr)) begin
         if (mode == MODE_PWM8) begin
            capture_compare_value_reg[7:0] <= wdata;
         end else begin
            capture_compare_value_reg <= {staging_reg, wdata};
         end
      end else if (isWrite(ofs, OFS_CAPTURE_COMPARE_VALUE_HI, byteWr) &&
                   mode == MODE_PWM8) begin
         capture_compare_value_reg[15:8] <= wdata;
      end else if (capture) begin
         capture_compare_value_reg <= count_reg;
      end
   end

   // PWM waveform: high until count reaches duty byte
   always_ff @(posedge clk) begin
      if (reset) begin
         pwmOut_reg <= 1'b0;
      end else if (mode == MODE_PWM8 && running_reg) begin
         pwmOut_reg <= count_reg[7:0] < capture_compare_value_reg[15:8];
      end else begin
         pwmOut_reg <= 1'b0;
      end
   end

   // Bus answer, one wait cycle per access
   always_ff @(posedge clk) begin
      if (reset) begin
         ack_reg <= 1'b0;
         rdata_reg <= UNMAPPED_READ;
         resp_reg <= RESP_OKAY;
      end else begin
         ack_reg <= access;
         resp_reg <= hit ? RESP_OKAY : RESP_DECODEERROR;
         rdata_reg <= UNMAPPED_READ;
         if (rd) begin
            case (ofs)
               OFS_CTRL: rdata_reg[7:0] <= ctrl_reg;
               OFS_IRQ_ENABLE: rdata_reg[CAPTURE_EVENT_FLAG_BIT] <= irqEnable_reg;
               OFS_IRQ_FLAG: rdata_reg[CAPTURE_EVENT_FLAG_BIT] <= captFlag_reg;
               OFS_RUN_STATUS: rdata_reg[RUN_BIT] <= running_reg;
               OFS_DEBUG_CTRL: rdata_reg[RUN_IN_DEBUG_HALT_BIT] <= run_in_debug_halt_reg;
               OFS_STAGING: rdata_reg[7:0] <= staging_reg;
               OFS_COUNT_LO: rdata_reg[7:0] <= count_reg[7:0];
               OFS_COUNT_HI: rdata_reg[7:0] <= staging_reg;
               OFS_CAPTURE_COMPARE_VALUE_LO: rdata_reg[7:0] <= capture_compare_value_reg[7:0];
               OFS_CAPTURE_COMPARE_VALUE_HI: rdata_reg[7:0] <= mode == MODE_PWM8 ?
                  capture_compare_value_reg[15:8] : staging_reg;
               default: rdata_reg <= UNMAPPED_READ;
            endcase
         end
      end
   end

   // Outputs
   always_comb begin
      busRsp.waitrequest = (busReq.read || busReq.write) && !ack_reg;
      busRsp.readdatavalid = 1'b0;
      busRsp.readdata = rdata_reg;
      busRsp.response = resp_reg;
   end
   assign irq = captFlag_reg && irqEnable_reg;
   assign pwmOut = pwmOut_reg;

endmodule
`default_nettype wire

// >>> testbench/timer_capture_regs_assertions.sv
// Port-level checker for the capture timer registers
`timescale 1ns/1ns
`default_nettype none
module timer_capture_regs_assertions
   import timer_capture_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire avmm_req_t busReq,
   input wire avmm_rsp_t busRsp,
   input wire logic eventIn,
   input wire logic debugHalt,
   input wire logic irq,
   input wire logic pwmOut
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   logic req;
   logic rdDone;
   logic take;
   logic [4:0] idx;
   logic irqEnable_reg;
   logic [2:0] mode_reg;
   // Bus decode seen at the ports
   assign req = busReq.read || busReq.write;
   assign idx = busReq.address[6:2];
   assign rdDone = busReq.read && !busRsp.waitrequest;
   assign take = busReq.write && busRsp.waitrequest && busReq.byteenable[0];
   // Shadow of irq enable and mode as written by software
   always_ff @(posedge clk) begin
      if (reset) begin
         irqEnable_reg <= 1'b0;
         mode_reg <= 3'h0;
      end else begin
         if (take && idx == OFS_IRQ_ENABLE) begin
            irqEnable_reg <= busReq.writedata[CAPTURE_EVENT_FLAG_BIT];
         end
         if (take && idx == OFS_CTRL) begin
            mode_reg <= busReq.writedata[6:4];
         end
      end
   end
   sequence sReqStart;
      req && busRsp.waitrequest;
   endsequence
   sequence sPwmOff;
      mode_reg != MODE_PWM8 && $past(mode_reg) != MODE_PWM8;
   endsequence
   chk_one_wait: assert property (sReqStart |=> !busRsp.waitrequest)
      else $error("access not answered after one wait cycle");
   chk_first_wait: assert property (req && !$past(req) |-> busRsp.waitrequest)
      else $error("new access answered without wait cycle");
   chk_upper_zero: assert property (rdDone |-> busRsp.readdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   chk_unmapped_err: assert property (rdDone && idx > OFS_CAPTURE_COMPARE_VALUE_HI |->
      busRsp.response == RESP_DECODEERROR && busRsp.readdata == UNMAPPED_READ)
      else $error("unmapped read not refused");
   chk_mapped_okay: assert property (rdDone && idx >= OFS_IRQ_ENABLE &&
      idx <= OFS_CAPTURE_COMPARE_VALUE_HI |-> busRsp.response == RESP_OKAY)
      else $error("mapped read not okay");
   chk_irq_masked: assert property (!irqEnable_reg && !$past(irqEnable_reg) |-> !irq)
      else $error("interrupt while disabled");
   chk_irq_fall: assert property ($fell(irq) |-> $past(req) || $past(req, 2))
      else $error("interrupt dropped without bus access");
   chk_pwm_quiet: assert property (sPwmOff ##0 $past(mode_reg, 2) != MODE_PWM8
      |-> !pwmOut)
      else $error("waveform outside PWM8 mode");
   chk_status_bits: assert property (rdDone && idx == OFS_RUN_STATUS |->
      busRsp.readdata[7:1] == 7'h00)
      else $error("status spare bits set");
endmodule
bind timer_capture_regs timer_capture_regs_assertions CHK (
   .clk(clk), .reset(reset), .busReq(busReq), .busRsp(busRsp),
   .eventIn(eventIn), .debugHalt(debugHalt), .irq(irq), .pwmOut(pwmOut));
`default_nettype wire

// >>> testbench/timer_capture_regs_bench.sv
// Self-checking bench for the capture timer registers
`timescale 1ns/1ns
`default_nettype none
module timer_capture_regs_bench;
   import timer_capture_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   avmm_req_t busReq = '0;
   avmm_rsp_t busRsp;
   logic eventIn = 1'b0;
   logic debugHalt = 1'b0;
   logic irq;
   logic pwmOut;
   int n_fail = 0;
   int comparisons = 0;
   int waited;
   int highs;
   logic [7:0] rdv;
   logic [7:0] a;
   logic [1:0] rsp;
   always #4 clk = ~clk;
   timer_capture_regs DUT (.clk(clk), .reset(reset), .busReq(busReq),
      .busRsp(busRsp), .eventIn(eventIn), .debugHalt(debugHalt),
      .irq(irq), .pwmOut(pwmOut));
   // One access, held until waitrequest is seen low
   task automatic acc(input logic rd, input logic [4:0] i, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      busReq <= '{rd, ~rd, {i, 2'b00}, 4'hF, {24'h0, d}};
      do begin
         @(posedge clk);
         n++;
      end while (busRsp.waitrequest !== 1'b0 && n < 50);
      if (n >= 50) n_fail++;
      // Answer taken at the edge that sees waitrequest low
      rdv = busRsp.readdata[7:0];
      rsp = busRsp.response;
      busReq.read <= 1'b0;
      busReq.write <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [4:0] i, input logic [7:0] d);
      acc(1'b0, i, d);
   endtask
   task automatic rc(input string nm, input logic [4:0] i, input logic [7:0] e);
      acc(1'b1, i, 8'h00);
      chk(nm, 16'(e), 16'(rdv));
   endtask
   // Wait for the interrupt, bounded
   task automatic wirq();
      waited = 0;
      while (irq !== 1'b1 && waited < 400) begin
         @(negedge clk);
         waited++;
      end
      chk("irq", 16'h1, 16'(irq));
   endtask
   // One rising then falling event, 17 cycles per call
   task automatic ev();
      @(posedge clk);
      eventIn <= 1'b1;
      repeat (8) @(posedge clk);
      eventIn <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   task automatic results();
      $display("comparisons %0d failures %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      #200000;
      n_fail++;
      results();
   end
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      for (int i = 5; i < 14; i++) rc("reset", i[4:0], 8'h00);
      acc(1'b1, 5'h1F, 8'h00);
      chk("unmapped", 16'(RESP_DECODEERROR), 16'(rsp));
      for (int m = 0; m < 8; m++) begin
         wr(OFS_CTRL, {1'b0, m[2:0], 4'h0});
         rc("mode", OFS_CTRL, {1'b0, m[2:0], 4'h0});
      end
      wr(OFS_STAGING, 8'h5A);
      rc("staging", OFS_STAGING, 8'h5A);
      wr(OFS_COUNT_HI, 8'h12);
      wr(OFS_COUNT_LO, 8'h34);
      rc("cntLo", OFS_COUNT_LO, 8'h34);
      rc("latched", OFS_STAGING, 8'h12);
      rc("cntHi", OFS_COUNT_HI, 8'h12);
      $display("test access done");
      wr(OFS_COUNT_HI, 8'h00);
      wr(OFS_COUNT_LO, 8'h00);
      wr(OFS_CAPTURE_COMPARE_VALUE_HI, 8'h01);
      wr(OFS_CAPTURE_COMPARE_VALUE_LO, 8'h00);
      wr(OFS_IRQ_ENABLE, 8'h01);
      wr(OFS_CTRL, 8'h01);
      rc("run", OFS_RUN_STATUS, 8'h01);
      wirq();
      chk("top", 16'h1, 16'(waited > 200));
      wr(OFS_CTRL, 8'h00);
      rc("stop", OFS_RUN_STATUS, 8'h00);
      wr(OFS_RUN_STATUS, 8'h01);
      rc("runRo", OFS_RUN_STATUS, 8'h00);
      wr(OFS_IRQ_ENABLE, 8'h00);
      chk("mask", 16'h0, 16'(irq));
      rc("flag", OFS_IRQ_FLAG, 8'h01);
      wr(OFS_IRQ_FLAG, 8'h01);
      rc("w1c", OFS_IRQ_FLAG, 8'h00);
      wr(OFS_IRQ_ENABLE, 8'h01);
      $display("test periodic done");
      wr(OFS_CTRL, 8'h21);
      ev();
      wirq();
      acc(1'b1, OFS_CAPTURE_COMPARE_VALUE_LO, 8'h00);
      a = rdv;
      @(negedge clk);
      chk("rdClear", 16'h0, 16'(irq));
      acc(1'b1, OFS_COUNT_LO, 8'h00);
      chk("goesOn", 16'h1, 16'(rdv > a && a != 8'h00));
      $display("test capture done");
      wr(OFS_CTRL, 8'h31);
      ev();
      ev();
      wirq();
      acc(1'b1, OFS_CAPTURE_COMPARE_VALUE_LO, 8'h00);
      chk("period", 16'h1, 16'(rdv == 8'h10 || rdv == 8'h11));
      rc("perHi", OFS_CAPTURE_COMPARE_VALUE_HI, 8'h00);
      $display("test frequency done");
      wr(OFS_CTRL, 8'h01);
      debugHalt <= 1'b1;
      repeat (4) @(posedge clk);
      acc(1'b1, OFS_COUNT_LO, 8'h00);
      a = rdv;
      repeat (20) @(posedge clk);
      rc("halted", OFS_COUNT_LO, a);
      wr(OFS_DEBUG_CTRL, 8'h01);
      acc(1'b1, OFS_COUNT_LO, 8'h00);
      a = rdv;
      repeat (5) @(posedge clk);
      acc(1'b1, OFS_COUNT_LO, 8'h00);
      chk("run_in_debug_halt", 16'h1, 16'(rdv != a));
      // Events during a halt are dropped
      wr(OFS_DEBUG_CTRL, 8'h00);
      wr(OFS_CTRL, 8'h21);
      wr(OFS_IRQ_FLAG, 8'h01);
      ev();
      rc("noEvent", OFS_IRQ_FLAG, 8'h00);
      debugHalt <= 1'b0;
      // Count write while counting
      wr(OFS_COUNT_HI, 8'h00);
      wr(OFS_COUNT_LO, 8'h80);
      acc(1'b1, OFS_COUNT_LO, 8'h00);
      chk("wrFirst", 16'h1, 16'(rdv >= 8'h80 && rdv <= 8'h88));
      $display("test debug done");
      wr(OFS_CTRL, 8'h70);
      wr(OFS_CAPTURE_COMPARE_VALUE_HI, 8'h04);
      wr(OFS_CAPTURE_COMPARE_VALUE_LO, 8'h0F);
      rc("duty", OFS_CAPTURE_COMPARE_VALUE_HI, 8'h04);
      wr(OFS_COUNT_HI, 8'h00);
      wr(OFS_COUNT_LO, 8'h00);
      wr(OFS_IRQ_FLAG, 8'h01);
      wr(OFS_CTRL, 8'h71);
      highs = 0;
      repeat (64) begin
         @(negedge clk);
         highs += int'(pwmOut === 1'b1);
      end
      chk("pwm", 16'h1, 16'(highs >= 12 && highs <= 20));
      wirq();
      $display("test pwm done");
      // Single shot: armed, started by an edge, stops at top
      wr(OFS_CTRL, 8'h60);
      wr(OFS_CAPTURE_COMPARE_VALUE_HI, 8'h00);
      wr(OFS_CAPTURE_COMPARE_VALUE_LO, 8'h20);
      wr(OFS_COUNT_HI, 8'h00);
      wr(OFS_COUNT_LO, 8'h00);
      wr(OFS_IRQ_FLAG, 8'h01);
      wr(OFS_CTRL, 8'h61);
      rc("armed", OFS_RUN_STATUS, 8'h00);
      ev();
      wirq();
      rc("shotEnd", OFS_RUN_STATUS, 8'h00);
      $display("test single done");
      // Pulse width: rise restarts, fall captures
      wr(OFS_IRQ_FLAG, 8'h01);
      wr(OFS_CTRL, 8'h41);
      ev();
      wirq();
      acc(1'b1, OFS_CAPTURE_COMPARE_VALUE_LO, 8'h00);
      chk("width", 16'h1, 16'(rdv inside {8'h07, 8'h08}));
      chk("pwClear", 16'h0, 16'(irq));
      $display("test pulse done");
      // Combined: no flag until the second rise, then stopped
      wr(OFS_CTRL, 8'h51);
      ev();
      chk("noFlag", 16'h0, 16'(irq));
      ev();
      wirq();
      rc("fpStop", OFS_RUN_STATUS, 8'h00);
      acc(1'b1, OFS_COUNT_LO, 8'h00);
      a = rdv;
      acc(1'b1, OFS_COUNT_LO, 8'h00);
      chk("frozen", 16'(a), 16'(rdv));
      acc(1'b1, OFS_CAPTURE_COMPARE_VALUE_LO, 8'h00);
      chk("fpWidth", 16'h1, 16'(rdv inside {8'h07, 8'h08}));
      $display("test combined done");
      // Timeout check: rise starts, top flags, fall stops
      wr(OFS_CTRL, 8'h10);
      wr(OFS_CAPTURE_COMPARE_VALUE_HI, 8'h00);
      wr(OFS_CAPTURE_COMPARE_VALUE_LO, 8'h05);
      wr(OFS_COUNT_HI, 8'h00);
      wr(OFS_COUNT_LO, 8'h00);
      wr(OFS_IRQ_FLAG, 8'h01);
      wr(OFS_CTRL, 8'h11);
      ev();
      wirq();
      rc("toStop", OFS_RUN_STATUS, 8'h00);
      $display("test timeout done");
      results();
   end
endmodule
`default_nettype wire
